// file: rtl/can_filter_defines.vh
// register offsets, field positions and reset values of the filter section address bank
// included by can_filter_table_section_addresses.v
`ifndef CAN_FILTER_DEFINES_VH
`define CAN_FILTER_DEFINES_VH

`define OFS_GROUP_START      12'h000
`define OFS_TABLE_END        12'h004
`define OFS_FILTER_CTRL      12'h008
`define OFS_COPY_STATUS      12'h00C

`define ADDR_FIELD_HI        11
`define ADDR_FIELD_LO        2
`define ADDR_FIELD_W         10

`define CTRL_MODE_HI         1
`define CTRL_MODE_LO         0
`define CTRL_FMO_BIT         2

`define MODE_OFF             2'h0
`define MODE_BYPASS          2'h1
`define MODE_ON              2'h2

`define RST_GROUP_START      10'h000
`define RST_TABLE_END        10'h000
`define RST_MODE             2'h0
`define RST_FMO              1'b0

`define WORDS_PER_OBJECT     2'h3

`endif

// file: rtl/can_filter_table_section_addresses.v
// filter look-up table section address bank with apb slave and message object copy engine
// assumes an apb master on clk, a receive buffer that presents a matched frame as three words
`timescale 1ns/100ps
`include "can_filter_defines.vh"

// What this block does
// - bits 11..2 hold grouped section start
// - section address writes only in bypass or off mode, control writable in every mode
// - group start word aligned, bits 1..0 zero
// - bits 31..12 of both section address registers read as zero
// - end register is object base when enabled
// - matched frame copied into object section
// - each object takes three table words
module can_filter_table_section_addresses #(
  parameter INDEX_W = 8
) (
  // clock and reset
  input  wire                clk,
  input  wire                nrst,
  // apb slave
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [11:0]         paddr,
  input  wire [31:0]         pwdata,
  output wire                pready,
  output reg  [31:0]         prdata,
  output wire                pslverr,
  // section addresses towards the filter
  output wire [9:0]          groupStartWord,
  output wire [9:0]          tableEndWord,
  output wire [1:0]          filterMode,
  output wire                fullMessageObjectEnable,
  // matched frame from the receive buffer
  input  wire                matchValid,
  output wire                matchReady,
  input  wire [INDEX_W-1:0]  matchIndex,
  input  wire [31:0]         frameWord0,
  input  wire [31:0]         frameWord1,
  input  wire [31:0]         frameWord2,
  // look-up table write port, word addressed
  output reg                 tableWrEn,
  output reg  [9:0]          tableWrAddr,
  output reg  [31:0]         tableWrData
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_COPY = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg  [9:0]   groupStart_q;
  reg  [9:0]   groupStart_d;
  reg  [9:0]   tableEnd_q;
  reg  [9:0]   tableEnd_d;
  reg  [1:0]   mode_q;
  reg  [1:0]   mode_d;
  reg          fmo_q;
  reg          fmo_d;
  reg  [2:0]   state_q;
  reg  [2:0]   state_d;
  reg  [1:0]   wordCnt_q;
  reg  [1:0]   wordCnt_d;
  reg  [9:0]   copyAddr_q;
  reg  [9:0]   copyAddr_d;
  reg  [95:0]  frame_q;
  reg  [95:0]  frame_d;
  reg  [15:0]  copyCount_q;
  reg  [15:0]  copyCount_d;

  wire         wrStrobe;
  wire         addrWritable;
  wire         addrHit;
  wire [INDEX_W+1:0] objProduct;
  wire [9:0]   objOffset;
  reg  [31:0]  readMux;
  reg  [31:0]  rdData_d;

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wrStrobe = psel & penable & pwrite;
  assign addrHit = (paddr == `OFS_GROUP_START) | (paddr == `OFS_TABLE_END) |
                   (paddr == `OFS_FILTER_CTRL) | (paddr == `OFS_COPY_STATUS);
  // unmapped accesses answer with an error but never stall the bus
  assign pslverr = psel & penable & ~addrHit;
  assign addrWritable = (mode_q == `MODE_OFF) | (mode_q == `MODE_BYPASS);

  assign groupStartWord = groupStart_q;
  assign tableEndWord = tableEnd_q;
  assign filterMode = mode_q;
  assign fullMessageObjectEnable = fmo_q;
  assign matchReady = fmo_q & (state_q == ST_IDLE);

  // object n starts three words per object above the section base
  assign objProduct = {{INDEX_W{1'b0}}, `WORDS_PER_OBJECT} * {2'b00, matchIndex};

  // the table is 1024 words deep, so the object offset wraps like the address
  generate
    if (INDEX_W >= 8) begin : gCutOffset
      assign objOffset = objProduct[9:0];
    end else begin : gPadOffset
      assign objOffset = {{(8 - INDEX_W){1'b0}}, objProduct};
    end
  endgenerate

  // register writes
  always @* begin
    groupStart_d = groupStart_q;
    tableEnd_d = tableEnd_q;
    mode_d = mode_q;
    fmo_d = fmo_q;
    if (wrStrobe) begin
      case (paddr)
        `OFS_GROUP_START: begin
          if (addrWritable)
            groupStart_d = pwdata[`ADDR_FIELD_HI:`ADDR_FIELD_LO];
        end
        `OFS_TABLE_END: begin
          if (addrWritable)
            tableEnd_d = pwdata[`ADDR_FIELD_HI:`ADDR_FIELD_LO];
        end
        // control stays writable in every mode, or the filter could never leave on mode
        `OFS_FILTER_CTRL: begin
          mode_d = pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
          fmo_d = pwdata[`CTRL_FMO_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // read mux, unmapped addresses read zero with pslverr
  always @* begin
    readMux = 32'h0000_0000;
    case (paddr)
      `OFS_GROUP_START: readMux = {20'h0_0000, groupStart_q, 2'h0};
      `OFS_TABLE_END:   readMux = {20'h0_0000, tableEnd_q, 2'h0};
      `OFS_FILTER_CTRL: readMux = {29'h0000_0000, fmo_q, mode_q};
      `OFS_COPY_STATUS: readMux = {copyCount_q, 15'h0000, (state_q != ST_IDLE)};
      default:          readMux = 32'h0000_0000;
    endcase
  end

  // read word captured in the setup cycle, so the access cycle returns a settled value;
  // the copy status can lag by one cycle when a copy finishes during the access
  always @* begin
    rdData_d = prdata;
    if (psel & ~penable)
      rdData_d = readMux;
  end

  // copy engine: three words per matched object into the object section
  always @* begin
    state_d = state_q;
    wordCnt_d = wordCnt_q;
    copyAddr_d = copyAddr_q;
    frame_d = frame_q;
    copyCount_d = copyCount_q;
    tableWrEn = 1'b0;
    tableWrAddr = copyAddr_q;
    tableWrData = frame_q[31:0];
    case (state_q)
      ST_IDLE: begin
        if (matchValid & matchReady) begin
          copyAddr_d = tableEnd_q + objOffset;
          frame_d = {frameWord2, frameWord1, frameWord0};
          wordCnt_d = 2'h0;
          state_d = ST_COPY;
        end
      end
      ST_COPY: begin
        tableWrEn = 1'b1;
        frame_d = {32'h0000_0000, frame_q[95:32]};
        copyAddr_d = copyAddr_q + 10'h001;
        wordCnt_d = wordCnt_q + 2'h1;
        if (wordCnt_q == (`WORDS_PER_OBJECT - 2'h1))
          state_d = ST_DONE;
      end
      // done cycle keeps matchReady low, so objects come at least five cycles apart
      ST_DONE: begin
        copyCount_d = copyCount_q + 16'h0001;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // one register stage for the whole bank, reset values from the header
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      groupStart_q <= `RST_GROUP_START;
      tableEnd_q <= `RST_TABLE_END;
      mode_q <= `RST_MODE;
      fmo_q <= `RST_FMO;
      state_q <= ST_IDLE;
      wordCnt_q <= 2'h0;
      copyAddr_q <= 10'h000;
      frame_q <= 96'h0;
      copyCount_q <= 16'h0000;
      prdata <= 32'h0000_0000;
    end else begin
      groupStart_q <= groupStart_d;
      tableEnd_q <= tableEnd_d;
      mode_q <= mode_d;
      fmo_q <= fmo_d;
      state_q <= state_d;
      wordCnt_q <= wordCnt_d;
      copyAddr_q <= copyAddr_d;
      frame_q <= frame_d;
      copyCount_q <= copyCount_d;
      prdata <= rdData_d;
    end
  end

endmodule // can_filter_table_section_addresses

// file: verif/can_filter_sections_properties.sv
// checker for the filter section address bank
// bound to can_filter_table_section_addresses, sees its ports only
`timescale 1ns/100ps
module can_filter_sections_checker #(parameter INDEX_W = 8) (
  input wire logic               clk, nrst, psel, penable, pwrite, matchValid, matchReady, tableWrEn,
  input wire logic               fullMessageObjectEnable,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata, prdata, frameWord0, tableWrData,
  input wire logic [9:0]         groupStartWord, tableEndWord, tableWrAddr,
  input wire logic [1:0]         filterMode,
  input wire logic [INDEX_W-1:0] matchIndex
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire wrAcc = psel && penable && pwrite;
  wire take = matchValid && matchReady;
  group_write_a: assert property (wrAcc && paddr == 12'h000 && !filterMode[1] |=> groupStartWord == $past(pwdata[11:2])) else $error("group start write lost");
  end_write_a: assert property (wrAcc && paddr == 12'h004 && !filterMode[1] |=> tableEndWord == $past(pwdata[11:2])) else $error("table end write lost");
  on_blocked_a: assert property (wrAcc && filterMode[1] && paddr < 12'h008 |=> $stable(groupStartWord) && $stable(tableEndWord)) else $error("write taken while on");
  group_read_a: assert property (psel && penable && !pwrite && paddr == 12'h000 |-> prdata == {20'h0_0000, groupStartWord, 2'b00}) else $error("group start read wrong");
  end_read_a: assert property (psel && penable && !pwrite && paddr == 12'h004 |-> prdata == {20'h0_0000, tableEndWord, 2'b00}) else $error("table end read wrong");
  copy_base_a: assert property (take |=> tableWrAddr == 10'($past(tableEndWord) + 10'd3 * $past(matchIndex)) && tableWrData == $past(frameWord0)) else $error("object base wrong");
  three_words_a: assert property (take |=> tableWrEn [*3] ##1 !tableWrEn) else $error("object not three words");
  ready_gate_a: assert property (!fullMessageObjectEnable |-> !matchReady) else $error("copy without enable");
  cover property (wrAcc && filterMode[1]);
  cover property (take);
  cover property (psel && !pwrite && paddr == 12'h004);
endmodule // can_filter_sections_checker
bind can_filter_table_section_addresses can_filter_sections_checker #(.INDEX_W(INDEX_W)) chk_i (.clk(clk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .matchValid(matchValid), .matchReady(matchReady), .matchIndex(matchIndex), .frameWord0(frameWord0),
  .tableWrEn(tableWrEn), .tableWrAddr(tableWrAddr), .tableWrData(tableWrData), .filterMode(filterMode),
  .groupStartWord(groupStartWord), .tableEndWord(tableEndWord), .fullMessageObjectEnable(fullMessageObjectEnable));

// file: verif/can_filter_table_section_addresses_tb_top.sv
// directed bench: apb register tests and one object copy
// assumes the design answers apb with pready and the checker is bound
`timescale 1ns/100ps
module can_filter_table_section_addresses_tb_top;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, matchValid = 0, pready, tableWrEn, pslverr, matchReady, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r, frameWord0 = 0, frameWord1 = 0, frameWord2 = 0, tableWrData;
  logic [7:0]  matchIndex = 8'h00;
  logic [9:0]  tableWrAddr, wa[4];
  logic [31:0] wd[4];
  int fails = 0, cmp_count = 0, n = 0, cyc = 0;
  can_filter_table_section_addresses dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .groupStartWord(),
    .tableEndWord(), .filterMode(), .fullMessageObjectEnable(), .matchValid(matchValid), .matchReady(matchReady),
    .matchIndex(matchIndex), .frameWord0(frameWord0), .frameWord1(frameWord1), .frameWord2(frameWord2),
    .tableWrEn(tableWrEn), .tableWrAddr(tableWrAddr), .tableWrData(tableWrData));
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (tableWrEn === 1'b1 && n < 4) begin
      wa[n] = tableWrAddr;
      wd[n] = tableWrData;
    end
    if (tableWrEn === 1'b1) n++;
    if (cyc == 3000) begin
      fails++;
      complete_run;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task xfer(input [11:0] a, input w, input [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task rd(input [11:0] a, input [31:0] e);
    xfer(a, 0, 0);
    chk(r, e);
  endtask
  task complete_run;
    $display("compares=%0d fails=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1;
    rd(12'h000, 32'h0000_0000);
    rd(12'h004, 32'h0000_0000);
    xfer(12'h000, 1, 32'h0000_07FC);
    rd(12'h000, 32'h0000_07FC);
    xfer(12'h008, 1, 32'h0000_0001);
    xfer(12'h004, 1, 32'hFFFF_F101);
    rd(12'h004, 32'h0000_0100);
    xfer(12'h008, 1, 32'h0000_0002);
    xfer(12'h000, 1, 32'h0000_0000);
    xfer(12'h004, 1, 32'h0000_0000);
    rd(12'h000, 32'h0000_07FC);
    rd(12'h004, 32'h0000_0100);
    rd(12'h008, 32'h0000_0002);
    xfer(12'h008, 1, 32'h0000_0000);
    xfer(12'h000, 1, 32'h0000_0100);
    rd(12'h000, 32'h0000_0100);
    rd(12'h010, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    $display("register tests done");
    xfer(12'h008, 1, 32'h0000_0001);
    matchIndex <= 8'h02; frameWord0 <= 32'h1111_1111; frameWord1 <= 32'h2222_2222; frameWord2 <= 32'h3333_3333;
    matchValid <= 1;
    repeat (4) @(posedge clk);
    chk(n, 0);
    xfer(12'h008, 1, 32'h0000_0005);
    while (matchReady !== 1'b1) @(posedge clk);
    matchValid <= 0;
    repeat (6) @(posedge clk);
    chk(n, 3);
    for (int i = 0; i < 3; i++) begin
      chk({22'h0, wa[i]}, 32'h0000_0046 + i);
      chk(wd[i], 32'h1111_1111 * (i + 1));
    end
    rd(12'h00C, 32'h0001_0000);
    rd(12'h008, 32'h0000_0005);
    $display("copy test done");
    complete_run;
  end
endmodule // can_filter_table_section_addresses_tb_top
